// ===== logic/pfd_pkg.sv
// constants and types for the phase detector and lock output block
// assumes a classic wishbone master on a 32-bit data bus
package pfd_pkg;

    // register byte offsets
    localparam logic [7:0] PFD_CFG_OFS = 8'h00;
    localparam logic [7:0] PFD_CTRL_OFS = 8'h04;
    localparam logic [7:0] PFD_STAT_OFS = 8'h08;
    localparam logic [7:0] PFD_CUR_OFS = 8'h0C;

    // values after reset
    localparam logic [7:0] PFD_CFG_RST = 8'h00;
    localparam logic PFD_PORT_RST = 1'b0;
    localparam logic [6:0] PFD_PCT_RST = 7'h46;

    // prescaler moduli
    localparam logic [6:0] PFD_MOD_LONG = 7'h41;
    localparam logic [6:0] PFD_MOD_SHORT = 7'h40;

    // current percentages, fine and coarse scales
    localparam logic [6:0] PFD_PCT_70 = 7'h46;
    localparam logic [6:0] PFD_PCT_80 = 7'h50;
    localparam logic [6:0] PFD_PCT_90 = 7'h5A;
    localparam logic [6:0] PFD_PCT_25 = 7'h19;
    localparam logic [6:0] PFD_PCT_50 = 7'h32;
    localparam logic [6:0] PFD_PCT_75 = 7'h4B;
    localparam logic [6:0] PFD_PCT_100 = 7'h64;

    // standby recovery states, gray except the wait back to run step
    typedef enum logic [1:0] {
        PFD_ST_RUN = 2'b00,
        PFD_ST_STANDBY_BIT = 2'b01,
        PFD_ST_WAIT = 2'b11
    } pfd_state_t;

    // configuration byte, msb first
    typedef struct packed {
        logic polarity_select;
        logic detector_select;
        logic lock_output_enable;
        logic standby_bit;
        logic [1:0] current_level_bits;
        logic step_size_select;
        logic spare;
    } pfd_cfg_t;

    // three-state pump drive: both low means floating
    typedef struct packed {
        logic source;
        logic sink;
    } pfd_pump_t;

    // wishbone request from master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [7:0] adr;
        logic [31:0] dat;
    } pfd_wb_req_t;

    // wishbone answer to master
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pfd_wb_rsp_t;

endpackage

// ===== logic/pfd_core.sv
// phase/frequency detectors, lock output, current decode, prescaler
// assumes divider pulses are synchronous to clock and much slower
`timescale 1ns/10ps

module pfd_core
    import pfd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire pfd_wb_req_t wb_req,
    output pfd_wb_rsp_t wb_rsp,
    input wire logic reference_compare_pulse,
    input wire logic vco_compare_pulse,
    input wire logic prescaler_modulus_ctl,
    output pfd_pump_t charge_pump_out,
    output logic ref_phase_out_n,
    output logic vco_phase_out_n,
    output logic lock_indicator,
    output logic [6:0] pump_current_pct,
    output logic modulus_probe,
    output logic prescaler_test_out
);

    // rising edge of a sampled pulse against its previous value
    function automatic logic rise(input logic cur, input logic prev);
        rise = cur & ~prev;
    endfunction

    // current decode from level bits, step size and port mode
    function automatic logic [6:0] pct(input logic [1:0] lvl,
                                       input logic step,
                                       input logic port);
        logic coarse;
        coarse = step & ~port;
        case (lvl)
            2'b00: pct = coarse ? PFD_PCT_25 : PFD_PCT_70;
            2'b01: pct = coarse ? PFD_PCT_50 : PFD_PCT_80;
            2'b10: pct = coarse ? PFD_PCT_75 : PFD_PCT_90;
            default: pct = PFD_PCT_100;
        endcase
    endfunction

    // register state
    pfd_cfg_t cfg_r; // configuration byte
    pfd_cfg_t cfg_nxt;
    logic port_mode_r; // general output is in port mode
    logic port_mode_nxt;
    logic ack_r; // wishbone acknowledge
    logic ack_nxt;
    logic [31:0] rdat_r; // wishbone read data
    logic [31:0] rdat_nxt;

    // detector state
    pfd_state_t state_r; // standby recovery
    pfd_state_t state_nxt;
    logic ref_d_r; // previous reference sample
    logic vco_d_r; // previous vco sample
    logic ref_flag_r; // reference edge seen, waiting for vco
    logic ref_flag_nxt;
    logic vco_flag_r; // vco edge seen, waiting for reference
    logic vco_flag_nxt;

    // output state
    pfd_pump_t pump_r;
    pfd_pump_t pump_nxt;
    logic ref_n_r;
    logic ref_n_nxt;
    logic vco_n_r;
    logic vco_n_nxt;
    logic lock_r;
    logic lock_nxt;
    logic [6:0] pct_r;
    logic [6:0] pct_nxt;

    // prescaler state
    logic [6:0] pre_cnt_r;
    logic [6:0] pre_cnt_nxt;
    logic pre_out_r;
    logic pre_out_nxt;
    logic mod_r;

    // bus decode and divider edge helpers
    logic req;
    logic wr;
    logic ref_edge;
    logic vco_edge;

    assign req = wb_req.cyc & wb_req.stb & ~ack_r;
    // write waits for the ack edge, so an abandoned cycle never lands
    assign wr = wb_req.cyc & wb_req.stb & ack_r & wb_req.we & wb_req.sel[0];
    assign ref_edge = rise(reference_compare_pulse, ref_d_r);
    assign vco_edge = rise(vco_compare_pulse, vco_d_r);

    // bus next state: ack one cycle after the request, write on ack edge
    always_comb begin
        cfg_nxt = cfg_r;
        port_mode_nxt = port_mode_r;
        ack_nxt = req;
        rdat_nxt = 32'h0000_0000;
        if (wr) begin
            case (wb_req.adr)
                PFD_CFG_OFS: cfg_nxt = pfd_cfg_t'(wb_req.dat[7:0]);
                PFD_CTRL_OFS: port_mode_nxt = wb_req.dat[0];
                default: begin
                    // read-only or unmapped: write dropped, still acked
                end
            endcase
        end
        if (req) begin
            case (wb_req.adr)
                PFD_CFG_OFS: rdat_nxt = {24'h00_0000, cfg_r};
                PFD_CTRL_OFS: rdat_nxt = {31'h0000_0000, port_mode_r};
                PFD_STAT_OFS: begin
                    rdat_nxt = {24'h00_0000, state_r, ref_flag_r,
                                vco_flag_r, ref_n_r, vco_n_r,
                                lock_r, mod_r};
                end
                PFD_CUR_OFS: rdat_nxt = {25'h000_0000, pct_r};
                default: rdat_nxt = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // bus registers; all config cleared at reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_r <= pfd_cfg_t'(PFD_CFG_RST);
            port_mode_r <= PFD_PORT_RST;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            cfg_r <= cfg_nxt;
            port_mode_r <= port_mode_nxt;
            ack_r <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    // standby recovery and detector flags
    always_comb begin
        state_nxt = state_r;
        ref_flag_nxt = 1'b0;
        vco_flag_nxt = 1'b0;
        case (state_r)
            PFD_ST_RUN: begin
                if (cfg_r.standby_bit) begin
                    state_nxt = PFD_ST_STANDBY_BIT;
                end else begin
                    // once both edges are in, clear both next cycle
                    ref_flag_nxt = (ref_flag_r & ~vco_flag_r)
                                   | ref_edge;
                    vco_flag_nxt = (vco_flag_r & ~ref_flag_r)
                                   | vco_edge;
                end
            end
            PFD_ST_STANDBY_BIT: begin
                // flags stay clear; detectors idle
                if (!cfg_r.standby_bit) begin
                    state_nxt = PFD_ST_WAIT;
                end
            end
            PFD_ST_WAIT: begin
                // pulses blocked until first vco pulse, then restart
                if (cfg_r.standby_bit) begin
                    state_nxt = PFD_ST_STANDBY_BIT;
                end else if (vco_edge) begin
                    state_nxt = PFD_ST_RUN;
                end
            end
            default: state_nxt = PFD_ST_STANDBY_BIT;
        endcase
    end

    // output next values from the next flags, so outputs align
    always_comb begin
        logic up;
        logic dn;
        logic pair_off;
        up = 1'b0;
        dn = 1'b0;
        pair_off = 1'b0;
        // polarity low: vco ahead gives down, reference ahead gives up; polarity high swaps them
        up = cfg_r.polarity_select ? vco_flag_nxt : ref_flag_nxt;
        dn = cfg_r.polarity_select ? ref_flag_nxt : vco_flag_nxt;
        pump_nxt.source = 1'b0;
        pump_nxt.sink = 1'b0;
        // pump only when selected and awake; both flags only in reset
        if (cfg_r.detector_select && !cfg_r.standby_bit) begin
            pump_nxt.source = up;
            pump_nxt.sink = dn;
        end
        pair_off = cfg_r.detector_select | cfg_r.standby_bit;
        if (pair_off) begin
            ref_n_nxt = 1'b1;
            vco_n_nxt = 1'b1;
        end else begin
            // polarity swaps which line carries which pulses
            ref_n_nxt = ~up;
            vco_n_nxt = ~dn;
        end
        if (!cfg_r.lock_output_enable) begin
            lock_nxt = 1'b0;
        end else if (cfg_r.standby_bit) begin
            lock_nxt = 1'b1; // enabled in standby: static high
        end else begin
            lock_nxt = ref_n_nxt & vco_n_nxt;
        end
        pct_nxt = pct(cfg_r.current_level_bits, cfg_r.step_size_select,
                      port_mode_r);
    end

    // detector and output registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= PFD_ST_RUN;
            ref_d_r <= 1'b0;
            vco_d_r <= 1'b0;
            ref_flag_r <= 1'b0;
            vco_flag_r <= 1'b0;
            pump_r <= '0;
            ref_n_r <= 1'b1;
            vco_n_r <= 1'b1;
            lock_r <= 1'b0;
            pct_r <= PFD_PCT_RST;
        end else begin
            state_r <= state_nxt;
            ref_d_r <= reference_compare_pulse;
            vco_d_r <= vco_compare_pulse;
            ref_flag_r <= ref_flag_nxt;
            vco_flag_r <= vco_flag_nxt;
            pump_r <= pump_nxt;
            ref_n_r <= ref_n_nxt;
            vco_n_r <= vco_n_nxt;
            lock_r <= lock_nxt;
            pct_r <= pct_nxt;
        end
    end

    // dual-modulus prescaler model on the block clock
    // low control divides by the longer modulus
    always_comb begin
        logic [6:0] last;
        last = (mod_r ? PFD_MOD_SHORT : PFD_MOD_LONG) - 7'h01;
        if (pre_cnt_r >= last) begin
            pre_cnt_nxt = 7'h00;
            pre_out_nxt = 1'b1;
        end else begin
            pre_cnt_nxt = pre_cnt_r + 7'h01;
            pre_out_nxt = 1'b0;
        end
    end

    // prescaler registers; modulus taken once per clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_cnt_r <= 7'h00;
            pre_out_r <= 1'b0;
            mod_r <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
            pre_out_r <= pre_out_nxt;
            mod_r <= prescaler_modulus_ctl;
        end
    end

    // all outputs straight from flops
    assign wb_rsp.ack = ack_r;
    assign wb_rsp.dat = rdat_r;
    assign charge_pump_out = pump_r;
    assign ref_phase_out_n = ref_n_r;
    assign vco_phase_out_n = vco_n_r;
    assign lock_indicator = lock_r;
    assign pump_current_pct = pct_r;
    assign modulus_probe = mod_r;
    assign prescaler_test_out = pre_out_r;

endmodule

// ===== verif/pfd_core_props.sv
// port checker for the phase detector and lock output block
// bound onto pfd_core; one clock, async reset high
`timescale 1ns/10ps
module pfd_core_props
    import pfd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire pfd_wb_req_t wb_req,
    input wire pfd_wb_rsp_t wb_rsp,
    input wire logic reference_compare_pulse,
    input wire logic vco_compare_pulse,
    input wire logic prescaler_modulus_ctl,
    input wire pfd_pump_t charge_pump_out,
    input wire logic ref_phase_out_n,
    input wire logic vco_phase_out_n,
    input wire logic lock_indicator,
    input wire logic [6:0] pump_current_pct,
    input wire logic modulus_probe,
    input wire logic prescaler_test_out
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic ref_d_r, vco_d_r; // last divider samples
    logic seen_r, chg_r; // a pulse seen; modulus moved this period
    logic [7:0] gap_r; // cycles since last prescaler pulse
    logic edge_c; // a divider edge as the detector takes it
    assign edge_c = (reference_compare_pulse & ~ref_d_r)
        | (vco_compare_pulse & ~vco_d_r);
    // helper flops; a modulus change spoils one period only
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ref_d_r <= 1'b0;
            vco_d_r <= 1'b0;
            seen_r <= 1'b0;
            chg_r <= 1'b0;
            gap_r <= 8'h00;
        end else begin
            ref_d_r <= reference_compare_pulse;
            vco_d_r <= vco_compare_pulse;
            seen_r <= seen_r | prescaler_test_out;
            chg_r <= (prescaler_modulus_ctl != modulus_probe)
                | (chg_r & ~prescaler_test_out);
            gap_r <= prescaler_test_out ? 8'h01 : gap_r + 8'h01;
        end
    end
    sequence s_pair_low;
        !ref_phase_out_n && !vco_phase_out_n;
    endsequence
    sequence s_pair_high;
        ref_phase_out_n && vco_phase_out_n;
    endsequence
    AST_ACK_TAKE: assert property (wb_req.cyc && wb_req.stb
        && !wb_rsp.ack |=> wb_rsp.ack) else $error("no ack");
    AST_ACK_PULSE: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack held");
    AST_LOCK_AND: assert property (lock_indicator |-> s_pair_high)
        else $error("lock high with pair low");
    AST_PUMP_PAIR: assert property (charge_pump_out != 2'b00
        |-> s_pair_high) else $error("pump and pair both active");
    AST_PAIR_BRIEF: assert property (s_pair_low |=> s_pair_high)
        else $error("coincident low too long");
    AST_PUMP_BRIEF: assert property (charge_pump_out == 2'b11
        |=> charge_pump_out == 2'b00) else $error("pump overlap long");
    AST_PAIR_CAUSE: assert property ($fell(ref_phase_out_n)
        || $fell(vco_phase_out_n) |-> $past(edge_c))
        else $error("pair pulse without edge");
    AST_PUMP_CAUSE: assert property ($rose(charge_pump_out.sink)
        || $rose(charge_pump_out.source) |-> $past(edge_c))
        else $error("pump pulse without edge");
    AST_PCT_LEGAL: assert property (pump_current_pct inside
        {7'h19, 7'h32, 7'h4B, 7'h46, 7'h50, 7'h5A, 7'h64})
        else $error("current code off scale");
    AST_PRESC_GAP: assert property (prescaler_test_out && seen_r
        && !chg_r && prescaler_modulus_ctl == modulus_probe
        |-> gap_r == (prescaler_modulus_ctl ? 8'h40 : 8'h41))
        else $error("prescaler period wrong");
endmodule
bind pfd_core pfd_core_props u_props (.clock(clock), .rst(rst),
    .wb_req(wb_req), .wb_rsp(wb_rsp),
    .reference_compare_pulse(reference_compare_pulse),
    .vco_compare_pulse(vco_compare_pulse),
    .prescaler_modulus_ctl(prescaler_modulus_ctl),
    .charge_pump_out(charge_pump_out), .ref_phase_out_n(ref_phase_out_n),
    .vco_phase_out_n(vco_phase_out_n), .lock_indicator(lock_indicator),
    .pump_current_pct(pump_current_pct), .modulus_probe(modulus_probe),
    .prescaler_test_out(prescaler_test_out));

// ===== verif/pfd_vco_model.sv
// loop filter and vco model on the pump side of the block
// assumes start is a one-cycle strobe; delay of zero never fires
`timescale 1ns/10ps
module pfd_vco_model
    import pfd_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire pfd_pump_t pump,
    input wire logic start,
    input wire logic [7:0] delay,
    output logic vco_pulse,
    output logic signed [15:0] tune
);
    logic [7:0] cnt_r; // cycles left to the divider pulse
    // one-cycle divider pulse; filter integrates source minus sink
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            vco_pulse <= 1'b0;
            tune <= 16'sh0000;
        end else begin
            cnt_r <= start ? delay
                : (cnt_r != 8'h00) ? cnt_r - 8'h01 : cnt_r;
            vco_pulse <= (cnt_r == 8'h01);
            tune <= tune + 16'(pump.source) - 16'(pump.sink);
        end
    end
endmodule

// ===== verif/pfd_core_tb.sv
// bench for the phase detector block: wishbone plus divider pulses
// assumes the vco model answers start after delay+1 edges
`timescale 1ns/10ps
module pfd_core_tb
    import pfd_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    pfd_wb_req_t wb_req = '0;
    pfd_wb_rsp_t wb_rsp;
    logic ref_p = 1'b0, start = 1'b0, ctl = 1'b0, vco_p;
    logic [7:0] dly = 8'h00;
    pfd_pump_t pump;
    logic ref_n, vco_n, lock, probe, tout;
    logic [6:0] pct;
    logic signed [15:0] tune, t0;
    logic [31:0] rd;
    int n_fail = 0, checks_done = 0, n;
    int cnt[5]; // low ref, low vco, sink, source, low lock
    int av[3] = '{2, 5, 3}, bv[3] = '{5, 2, 3};
    logic [6:0] fine[4] = '{PFD_PCT_70, PFD_PCT_80, PFD_PCT_90, PFD_PCT_100};
    logic [6:0] crs[4] = '{PFD_PCT_25, PFD_PCT_50, PFD_PCT_75, PFD_PCT_100};
    pfd_core DUT (.clock(clock), .rst(rst), .wb_req(wb_req),
        .wb_rsp(wb_rsp), .reference_compare_pulse(ref_p),
        .vco_compare_pulse(vco_p), .prescaler_modulus_ctl(ctl),
        .charge_pump_out(pump), .ref_phase_out_n(ref_n),
        .vco_phase_out_n(vco_n), .lock_indicator(lock),
        .pump_current_pct(pct), .modulus_probe(probe),
        .prescaler_test_out(tout));
    pfd_vco_model VCO (.clock(clock), .rst(rst), .pump(pump),
        .start(start), .delay(dly), .vco_pulse(vco_p), .tune(tune));
    initial forever #25 clock = ~clock;
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %h, expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d, input logic [3:0] sel);
        int i;
        wb_req <= '{1'b1, 1'b1, we, sel, a, d};
        for (i = 0; i < 20; i++) begin
            @(posedge clock);
            if (wb_rsp.ack === 1'b1) break;
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
        @(posedge clock);
        if (i == 20) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    // reference edge at a, vco edge at b; counts each output
    task automatic pair(input int a, input int b);
        cnt = '{default: 0};
        dly <= 8'(b - 1);
        t0 = tune;
        for (int i = 0; i < 16; i++) begin
            start <= (i == 0);
            ref_p <= (i == a);
            @(posedge clock);
            cnt[0] += int'(ref_n === 1'b0);
            cnt[1] += int'(vco_n === 1'b0);
            cnt[2] += int'(pump.sink === 1'b1);
            cnt[3] += int'(pump.source === 1'b1);
            cnt[4] += int'(lock === 1'b0);
        end
    endtask
    // bounded search for two prescaler pulses under modulus m
    task automatic period(input logic m);
        ctl <= m;
        repeat (140) @(posedge clock);
        for (n = 0; n < 200 && tout !== 1'b1; n++) @(posedge clock);
        if (n >= 200) begin
            n_fail++;
            tally_and_finish();
        end
        for (n = 1; n < 200; n++) begin
            @(posedge clock);
            if (tout === 1'b1) break;
        end
        cmp(n, m ? 64 : 65);
        cmp(probe, m);
        if (n >= 200) tally_and_finish();
    endtask
    initial begin
        int lr, lv, er, ev;
        logic [6:0] ep;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        wb(1'b0, PFD_CFG_OFS, 32'h0, 4'hF);
        cmp(rd, 32'h0);
        cmp(lock, 1'b0);
        cmp(pct, PFD_PCT_RST);
        $display("reset test done");
        // lead, lag and match under each polarity and detector choice
        for (int k = 0; k < 12; k++) begin
            wb(1'b1, PFD_CFG_OFS, {24'h0, k[0], k[1], 6'b101100}, 4'hF);
            pair(av[k / 4], bv[k / 4]);
            lr = (bv[k / 4] > av[k / 4]) ? bv[k / 4] - av[k / 4] + 1 : 1;
            lv = (av[k / 4] > bv[k / 4]) ? av[k / 4] - bv[k / 4] + 1 : 1;
            er = k[0] ? lv : lr;
            ev = k[0] ? lr : lv;
            cmp(cnt[0], k[1] ? 0 : er);
            cmp(cnt[1], k[1] ? 0 : ev);
            cmp(cnt[2], k[1] ? ev : 0);
            cmp(cnt[3], k[1] ? er : 0);
            cmp(cnt[4], k[1] ? 0 : (lr > lv ? lr : lv));
            cmp(32'(tune - t0), k[1] ? er - ev : 0);
        end
        $display("detector test done");
        wb(1'b1, PFD_CFG_OFS, 32'h70, 4'hF);
        pair(2, 5);
        cmp(cnt[2] + cnt[3] + cnt[4], 0);
        wb(1'b1, PFD_CFG_OFS, 32'h10, 4'hF);
        pair(2, 5);
        cmp(cnt[0] + cnt[1], 0);
        cmp(cnt[4], 16);
        wb(1'b0, PFD_STAT_OFS, 32'h0, 4'hF);
        cmp(rd, 32'h4C);
        wb(1'b1, PFD_CFG_OFS, 32'h20, 4'hF);
        pair(2, 5);
        cmp(cnt[0] + cnt[1], 0);
        pair(2, 5);
        cmp(cnt[0], 4);
        $display("standby test done");
        for (int k = 0; k < 16; k++) begin
            wb(1'b1, PFD_CTRL_OFS, {31'h0, k[3]}, 4'hF);
            wb(1'b1, PFD_CFG_OFS, {28'h0, k[1:0], k[2], 1'b0}, 4'hF);
            wb(1'b0, PFD_CUR_OFS, 32'h0, 4'hF);
            ep = (k[2] && !k[3]) ? crs[k[1:0]] : fine[k[1:0]];
            cmp(rd, ep);
            cmp(pct, ep);
        end
        wb(1'b1, PFD_CUR_OFS, 32'h0, 4'hF);
        wb(1'b1, PFD_CFG_OFS, 32'hFF, 4'hE);
        wb(1'b0, PFD_CUR_OFS, 32'h0, 4'hF);
        cmp(rd, PFD_PCT_100);
        wb(1'b0, 8'h10, 32'h0, 4'hF);
        cmp(rd, 32'h0);
        wb(1'b0, PFD_CFG_OFS, 32'h0, 4'hF);
        cmp(rd, 32'h0E);
        wb(1'b0, PFD_CTRL_OFS, 32'h0, 4'hF);
        cmp(rd, 32'h1);
        $display("current test done");
        period(1'b0);
        period(1'b1);
        $display("prescaler test done");
        tally_and_finish();
    end
endmodule
